// ==== dmamc_sync2.sv ====
/*
 * Two-flop synchroniser for asynchronous level inputs.
 * Assumes the inputs come from pins outside the clk_sys domain.
 */
`timescale 1ns/10ps

module dmamc_sync2 #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic             seeded_r;

    // Pins idle high; both flops start high so no false edge after reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '1;
            sync_r <= '1;
        end else if (ce) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    // Output shows reset_val under reset and until the first enabled clock after release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seeded_r <= 1'b0;
        end else if (ce) begin
            seeded_r <= 1'b1;
        end
    end

    assign sync_out = seeded_r ? sync_r : reset_val;

endmodule : dmamc_sync2

// ==== dmamc_sub.sv ====
/*
 * Sequencer of one DMA sub-channel: waits for its activation, issues one
 * transfer request, waits for the engine to finish, then lets the source
 * settle for one cycle before it may fire again.
 * Assumes done comes from the transfer engine on clk_sys.
 */
`timescale 1ns/10ps

module dmamc_sub (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic act,
    input  wire logic done,
    output logic      req,
    output logic      busy,
    output logic      fin
);

    typedef enum logic [2:0] {
        DMAMC_IDLE  = 3'b001,
        DMAMC_BUSY  = 3'b010,
        DMAMC_RECOV = 3'b100
    } dmamc_sub_st_t;

    dmamc_sub_st_t st_r;
    logic          req_r;
    logic          fin_r;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r  <= DMAMC_IDLE;
            req_r <= 1'b0;
            fin_r <= 1'b0;
        end else if (ce) begin
            req_r <= 1'b0;
            fin_r <= 1'b0;
            case (st_r)
                DMAMC_IDLE: begin
                    if (enable && act) begin
                        st_r  <= DMAMC_BUSY;
                        req_r <= 1'b1;
                    end
                end
                DMAMC_BUSY: begin
                    if (done) begin
                        st_r  <= DMAMC_RECOV;
                        fin_r <= 1'b1;
                    end else if (!enable) begin
                        st_r <= DMAMC_IDLE;
                    end
                end
                // One cycle lets a cleared source flag drop before re-arming
                DMAMC_RECOV: begin
                    st_r <= DMAMC_IDLE;
                end
                default: begin
                    st_r <= DMAMC_IDLE;
                end
            endcase
        end
    end

    assign req  = req_r;
    assign fin  = fin_r;
    assign busy = (st_r == DMAMC_BUSY);

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence s_armed;
        ce && st_r == DMAMC_IDLE && enable && act;
    endsequence

    property p_start;
        @(posedge clk_sys) disable iff (!rstn)
        s_armed |=> req && busy;
    endproperty

    a_start_request: assert property (p_start)
        else $error("Enabled activation did not raise a request");

    a_req_needs_enable: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(req) |-> $past(enable) && $past(act))
        else $error("Request raised without enable and activation");

    a_fin_settles: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (fin && ce) |=> !busy && !req)
        else $error("Sub-channel re-armed during settle cycle");

endmodule : dmamc_sub

// ==== dmamc_top.sv ====
/*
 * Constants package and top of the DMA channel mode and acknowledge control.
 * Holds the band control register (mode, addressing, acknowledge and
 * transfer-enable bits), per-sub-channel activation factors, transfer
 * sequencing, source clearing and interrupt forwarding.
 * Assumes an AHB-Lite master on clk_sys, peripheral interrupt flags and the
 * transfer engine on clk_sys, and request pins from outside.
 */
// Operation
// - Bits 15, 14 pick full (1) or short (0) address mode, channels 1, 0.
// - In short address mode, A and B sub-channels run as independent channels.
// - Bits 13, 12 pick single (1) or dual (0) addressing, B of channels 1, 0.
// - In full address mode the single-address bit of that channel has no effect.
// - Bits 11..8 are acknowledge bits for 1B, 1A, 0B, 0A; reset value 0.
// - Enable and acknowledge both set: transfer clears the selected internal source.
// - Enable and acknowledge both set: source raises no processor interrupt.
// - Enable set, acknowledge clear: source stays set and may interrupt too.
// - Enable clear: source request passes through regardless of acknowledge.
// - Enable set: wait for selected activation and transfer when it arrives.
// - Four-bit factor per sub-channel picks its activation source.

package dmamc_pkg;
    localparam int          NSUB       = 4;
    localparam int          NSRC       = 16;
    localparam int          FW         = 4;
    localparam logic [7:0]  OFS_BAND   = 8'h00;
    localparam logic [7:0]  OFS_FACTOR = 8'h04;
    localparam logic [7:0]  OFS_STAT   = 8'h08;
    localparam logic [7:0]  OFS_MASK   = 8'h0C;
    localparam int          BIT_FULL_ADDR_SEL_CH0   = 14;
    localparam int          BIT_SINGLE_ADDR_SEL_CH0B   = 12;
    localparam int          BIT_ACK0   = 8;
    localparam int          BIT_TEN0   = 4;
    localparam logic [15:0] BAND_RST   = 16'h0000;
    localparam logic [15:0] BAND_WMASK = 16'hFFF0;
    localparam logic [15:0] FACTOR_RST = 16'h0000;
    localparam logic [3:0]  FAC_PIN_EDGE  = 4'h2;
    localparam logic [3:0]  FAC_PIN_LEVEL = 4'h3;
    localparam logic [3:0]  FAC_ADC       = 4'h1;
    localparam logic [3:0]  FAC_INT_LO    = 4'h4;
    localparam logic [3:0]  FAC_INT_HI    = 4'hD;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

    // Factor codes that name an on-chip interrupt source
    function automatic logic is_internal(input logic [3:0] f);
        is_internal = (f == FAC_ADC) || (f >= FAC_INT_LO && f <= FAC_INT_HI);
    endfunction : is_internal
endpackage : dmamc_pkg

`timescale 1ns/10ps

module dmamc_top (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] src_req,
    input  wire logic [3:0]  dreq_n,
    input  wire logic [3:0]  xfer_done,
    output logic      [3:0]  xfer_req,
    output logic      [15:0] src_clr,
    output logic      [15:0] irq_fwd,
    output logic      [1:0]  full_addr,
    output logic      [1:0]  single_addr,
    output logic             irq
);

    logic [15:0] band_r;
    logic [15:0] factor_r;
    logic [3:0]  stat_r;
    logic [3:0]  mask_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [15:0] src_clr_r;
    logic [15:0] irq_fwd_r;
    logic [1:0]  full_addr_r;
    logic [1:0]  single_addr_r;
    logic        irq_r;
    logic [3:0]  dreq_s;
    logic [3:0]  dreq_prev_r;
    logic [3:0]  act;
    logic [3:0]  busy;
    logic [3:0]  fin;
    logic [3:0]  ten;
    logic [3:0]  ack;
    logic [15:0] supp;
    logic [15:0] clr_nxt;
    logic        addr_ok;

    function automatic logic [3:0] fac_of(input logic [15:0] fr, input int s);
        fac_of = fr[s*dmamc_pkg::FW +: dmamc_pkg::FW];
    endfunction : fac_of

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ----------------------------------------------------------------
    assign addr_ok = hsel && hready && (htrans == dmamc_pkg::HTRANS_NONSEQ);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hreadyout_r <= 1'b0;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            hrdata_r    <= 32'h0000_0000;
        end else if (ce) begin
            hreadyout_r <= 1'b1;
            wr_pend_r   <= addr_ok && hwrite;
            wr_addr_r   <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                case (haddr[7:0])
                    dmamc_pkg::OFS_BAND:   hrdata_r <= {16'h0000, band_r};
                    dmamc_pkg::OFS_FACTOR: hrdata_r <= {16'h0000, factor_r};
                    dmamc_pkg::OFS_STAT:   hrdata_r <= {28'h0000000, stat_r};
                    dmamc_pkg::OFS_MASK:   hrdata_r <= {28'h0000000, mask_r};
                    default:               hrdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Band control: mode, addressing, acknowledge, transfer enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            band_r <= dmamc_pkg::BAND_RST;
        end else if (ce) begin
            if (wr_pend_r && wr_addr_r == dmamc_pkg::OFS_BAND) begin
                band_r <= hwdata[15:0] & dmamc_pkg::BAND_WMASK;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            factor_r <= dmamc_pkg::FACTOR_RST;
        end else if (ce) begin
            if (wr_pend_r && wr_addr_r == dmamc_pkg::OFS_FACTOR) begin
                factor_r <= hwdata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt: sticky transfer-end status, write one to clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_r <= 4'h0;
            stat_r <= 4'h0;
            irq_r  <= 1'b0;
        end else if (ce) begin
            if (wr_pend_r && wr_addr_r == dmamc_pkg::OFS_MASK) begin
                mask_r <= hwdata[3:0];
            end
            // A completion in the clearing cycle survives the clear
            if (wr_pend_r && wr_addr_r == dmamc_pkg::OFS_STAT) begin
                stat_r <= (stat_r & ~hwdata[3:0]) | fin;
            end else begin
                stat_r <= stat_r | fin;
            end
            irq_r <= |(stat_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // Activation and sub-channel sequencers
    // ----------------------------------------------------------------
    dmamc_sync2 #(
        .WIDTH (4)
    ) u_sync (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .ce        (ce),
        .async_in  (dreq_n),
        .reset_val (4'hF),
        .sync_out  (dreq_s)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dreq_prev_r <= 4'hF;
        end else if (ce) begin
            dreq_prev_r <= dreq_s;
        end
    end

    // Sub-channel s: 0 = 0A, 1 = 0B, 2 = 1A, 3 = 1B
    always_comb begin
        for (int s = 0; s < dmamc_pkg::NSUB; s++) begin
            logic [3:0] f;
            f      = fac_of(factor_r, s);
            ten[s] = band_r[dmamc_pkg::BIT_TEN0 + s];
            ack[s] = band_r[dmamc_pkg::BIT_ACK0 + s];
            if (dmamc_pkg::is_internal(f)) begin
                act[s] = src_req[f];
            end else if (f == dmamc_pkg::FAC_PIN_EDGE) begin
                act[s] = dreq_prev_r[s] && !dreq_s[s];
            end else if (f == dmamc_pkg::FAC_PIN_LEVEL) begin
                act[s] = !dreq_s[s];
            end else begin
                act[s] = 1'b0;
            end
            // B runs on its own only in short address mode
            if (s[0] && band_r[dmamc_pkg::BIT_FULL_ADDR_SEL_CH0 + s/2]) begin
                act[s] = 1'b0;
            end
        end
    end

    for (genvar g = 0; g < dmamc_pkg::NSUB; g++) begin : g_sub
        dmamc_sub u_sub (
            .clk_sys (clk_sys),
            .rstn    (rstn),
            .ce      (ce),
            .enable  (ten[g]),
            .act     (act[g]),
            .done    (xfer_done[g]),
            .req     (xfer_req[g]),
            .busy    (busy[g]),
            .fin     (fin[g])
        );
    end

    // ----------------------------------------------------------------
    // Source clearing and interrupt forwarding
    // ----------------------------------------------------------------
    always_comb begin
        supp    = 16'h0000;
        clr_nxt = 16'h0000;
        for (int s = 0; s < dmamc_pkg::NSUB; s++) begin
            logic [3:0] f;
            f = fac_of(factor_r, s);
            if (dmamc_pkg::is_internal(f) && ten[s] && ack[s]) begin
                supp[f] = 1'b1;
                if (busy[s] && xfer_done[s]) begin
                    clr_nxt[f] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            src_clr_r <= 16'h0000;
            irq_fwd_r <= 16'h0000;
        end else if (ce) begin
            src_clr_r <= clr_nxt;
            irq_fwd_r <= src_req & ~supp;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            full_addr_r   <= 2'b00;
            single_addr_r <= 2'b00;
        end else if (ce) begin
            for (int c = 0; c < 2; c++) begin
                full_addr_r[c]   <= band_r[dmamc_pkg::BIT_FULL_ADDR_SEL_CH0 + c];
                single_addr_r[c] <= band_r[dmamc_pkg::BIT_SINGLE_ADDR_SEL_CH0B + c]
                                    && !band_r[dmamc_pkg::BIT_FULL_ADDR_SEL_CH0 + c];
            end
        end
    end

    assign hrdata      = hrdata_r;
    assign hreadyout   = hreadyout_r;
    assign hresp       = 1'b0;
    assign src_clr     = src_clr_r;
    assign irq_fwd     = irq_fwd_r;
    assign full_addr   = full_addr_r;
    assign single_addr = single_addr_r;
    assign irq         = irq_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_fwd_suppress: assert property (
        ce && ten[0] && ack[0] && dmamc_pkg::is_internal(fac_of(factor_r, 0))
        |=> !irq_fwd[fac_of($past(factor_r), 0)])
        else $error("Acknowledged source still forwarded");

    a_fwd_pass_off: assert property (
        ce && src_req[5] && !(|supp[5]) |=> irq_fwd[5])
        else $error("Unsuppressed source not forwarded");

    a_clear_on_done: assert property (
        ce && busy[0] && xfer_done[0] && ack[0] && ten[0]
        && dmamc_pkg::is_internal(fac_of(factor_r, 0))
        |=> src_clr[fac_of($past(factor_r), 0)])
        else $error("Acknowledged transfer did not clear its source");

    a_no_clear_noack: assert property (
        ce && supp == 16'h0000 |=> src_clr == 16'h0000)
        else $error("Source cleared without acknowledge");

    a_single_full: assert property (
        ce && band_r[dmamc_pkg::BIT_FULL_ADDR_SEL_CH0] |=> !single_addr[0])
        else $error("Single addressing reported in full address mode");

    a_single_follow: assert property (
        ce && band_r[dmamc_pkg::BIT_SINGLE_ADDR_SEL_CH0B + 1] && !band_r[dmamc_pkg::BIT_FULL_ADDR_SEL_CH0 + 1]
        |=> single_addr[1])
        else $error("Single addressing not reported");

    a_b_blocked: assert property (
        ce && band_r[dmamc_pkg::BIT_FULL_ADDR_SEL_CH0] |=> !xfer_req[1])
        else $error("B sub-channel activated in full address mode");

    a_pin_no_ack: assert property (
        ce && ten[0] && ack[0] && !dmamc_pkg::is_internal(fac_of(factor_r, 0))
        && busy[0] && xfer_done[0] |=> !src_clr[fac_of($past(factor_r), 0)])
        else $error("Pin transfer cleared an internal source");

    a_stat_set: assert property (
        ce && fin[0] |=> stat_r[0])
        else $error("Completion lost from status");

endmodule : dmamc_top

// ==== dmamc_periph.sv ====
/*
 * Model of the far side: internal interrupt source flags and the transfer
 * engine that answers each transfer request with a done pulse.
 * Assumes everything runs on clk_sys; raise and cpu_clr are one-cycle pulses.
 */
`timescale 1ns/10ps

module dmamc_periph #(
    parameter int DLY = 2
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [3:0]  xfer_req,
    input  wire logic [15:0] src_clr,
    input  wire logic [15:0] raise,
    input  wire logic [15:0] cpu_clr,
    output logic      [15:0] src_req,
    output logic      [3:0]  xfer_done,
    output logic      [7:0]  req_cnt [4]
);
    logic [3:0] cnt_r [4];

    // ------------------------------------------------------------
    // Source flags
    // ------------------------------------------------------------
    // A flag stays pending until the unit or the processor clears it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            src_req <= 16'h0000;
        end else begin
            src_req <= (src_req | raise) & ~src_clr & ~cpu_clr;
        end
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    // Later sub-channels answer more slowly, so quick and slow completions both occur
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int s = 0; s < 4; s++) begin
                cnt_r[s]     <= 4'h0;
                req_cnt[s]   <= 8'h00;
                xfer_done[s] <= 1'b0;
            end
        end else begin
            for (int s = 0; s < 4; s++) begin
                xfer_done[s] <= (cnt_r[s] == 4'h1);
                if (xfer_req[s]) begin
                    cnt_r[s]   <= 4'(DLY + 2 * s);
                    req_cnt[s] <= req_cnt[s] + 8'h01;
                end else if (cnt_r[s] != 4'h0) begin
                    cnt_r[s] <= cnt_r[s] - 4'h1;
                end
            end
        end
    end
endmodule : dmamc_periph

// ==== tb_dma_channel_mode_and_ack_control.sv ====
/*
 * Self-checking bench of the channel mode and acknowledge control.
 * Assumes a single AHB-Lite slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/10ps

module tb_dma_channel_mode_and_ack_control;
    logic        clk_sys, rstn, hsel, hwrite, ce;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, full_addr, single_addr;
    logic        hreadyout, hresp, irq;
    logic [15:0] src_req, src_clr, irq_fwd, raise, cpu_clr;
    logic [3:0]  dreq_n, xfer_done, xfer_req;
    logic [7:0]  req_cnt [4];
    logic [7:0]  c0, c1;
    logic [15:0] bv [4] = '{16'hFFFF, 16'h3000, 16'h8000, 16'h6F00};
    int          fail_count = 0;
    int          n_compared = 0;

    dmamc_top dmamc_top_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .src_req(src_req), .dreq_n(dreq_n), .xfer_done(xfer_done), .xfer_req(xfer_req),
        .src_clr(src_clr), .irq_fwd(irq_fwd), .full_addr(full_addr),
        .single_addr(single_addr), .irq(irq));

    dmamc_periph dmamc_periph_i (.clk_sys(clk_sys), .rstn(rstn), .xfer_req(xfer_req),
        .src_clr(src_clr), .raise(raise), .cpu_clr(cpu_clr), .src_req(src_req),
        .xfer_done(xfer_done), .req_cnt(req_cnt));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= dmamc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        check("bus wait", 32'(n < 100), 32'h1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        repeat (2) @(posedge clk_sys);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(nm, x, exp);
    endtask : rd_chk

    task automatic pulse(input logic [15:0] r, input logic [15:0] c);
        @(posedge clk_sys);
        raise   <= r;
        cpu_clr <= c;
        @(posedge clk_sys);
        raise   <= 16'h0000;
        cpu_clr <= 16'h0000;
    endtask : pulse

    // Bounded wait for a request pulse, then let the engine and settle cycle finish
    task automatic wait_req(input int s);
        for (int n = 0; n < 30 && xfer_req[s] !== 1'b1; n++) @(posedge clk_sys);
        repeat (12) @(posedge clk_sys);
    endtask : wait_req

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        fail_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; ce = 1'b1;
        hwdata = 32'h0; dreq_n = 4'hF; raise = 16'h0000; cpu_clr = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_chk("band reset", dmamc_pkg::OFS_BAND, 32'h0);
        rd_chk("factor reset", dmamc_pkg::OFS_FACTOR, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(dmamc_pkg::OFS_BAND, {16'h0, bv[i]});
            rd_chk("band rb", dmamc_pkg::OFS_BAND, {16'h0, bv[i] & dmamc_pkg::BAND_WMASK});
            check("full_addr", full_addr, {bv[i][15], bv[i][14]});
            check("single_addr", single_addr, {bv[i][13] & ~bv[i][15],
                  bv[i][12] & ~bv[i][14]});
        end
        // Enable and acknowledge on 0A, factor 5; an unselected source passes
        wr(dmamc_pkg::OFS_FACTOR, 32'h0005);
        wr(dmamc_pkg::OFS_BAND, 32'h0110);
        c0 = req_cnt[0];
        pulse(16'h0080, 16'h0000);
        repeat (4) @(posedge clk_sys);
        check("other src fwd", irq_fwd[7], 1'b1);
        check("no xfer other", req_cnt[0], c0);
        pulse(16'h0020, 16'h0080);
        repeat (2) @(posedge clk_sys);
        check("ack suppress", irq_fwd[5], 1'b0);
        wait_req(0);
        check("ack xfer", req_cnt[0], c0 + 8'h01);
        check("ack cleared", src_req[5], 1'b0);
        rd_chk("status", dmamc_pkg::OFS_STAT, 32'h1);
        check("irq masked", irq, 1'b0);
        wr(dmamc_pkg::OFS_MASK, 32'h1);
        check("irq on", irq, 1'b1);
        wr(dmamc_pkg::OFS_STAT, 32'h1);
        check("irq cleared", irq, 1'b0);
        // Enable without acknowledge: source stays pending and forwards
        wr(dmamc_pkg::OFS_BAND, 32'h0010);
        c0 = req_cnt[0];
        pulse(16'h0020, 16'h0000);
        wait_req(0);
        check("noack kept", src_req[5], 1'b1);
        check("noack fwd", irq_fwd[5], 1'b1);
        check("noack xfer", req_cnt[0] != c0, 1'b1);
        wr(dmamc_pkg::OFS_BAND, 32'h0100);
        pulse(16'h0000, 16'h0020);
        // Enable clear with acknowledge set: passes through, no transfer
        c0 = req_cnt[0];
        pulse(16'h0020, 16'h0000);
        repeat (6) @(posedge clk_sys);
        check("ten0 fwd", irq_fwd[5], 1'b1);
        check("ten0 idle", req_cnt[0], c0);
        pulse(16'h0000, 16'h0020);
        // Pin level activation with acknowledge: source index 3 untouched
        wr(dmamc_pkg::OFS_FACTOR, 32'h0003);
        wr(dmamc_pkg::OFS_BAND, 32'h0110);
        pulse(16'h0008, 16'h0000);
        c0 = req_cnt[0];
        dreq_n <= 4'hE;
        wait_req(0);
        dreq_n <= 4'hF;
        check("pin xfer", req_cnt[0] != c0, 1'b1);
        check("pin src kept", src_req[3], 1'b1);
        check("pin src fwd", irq_fwd[3], 1'b1);
        wr(dmamc_pkg::OFS_BAND, 32'h0000);
        pulse(16'h0000, 16'h0008);
        // Pin falling edge on 1A: one transfer although the pin stays low
        wr(dmamc_pkg::OFS_FACTOR, 32'h0200);
        wr(dmamc_pkg::OFS_BAND, 32'h0040);
        c0 = req_cnt[2];
        dreq_n <= 4'hB;
        wait_req(2);
        check("edge once", req_cnt[2], c0 + 8'h01);
        dreq_n <= 4'hF;
        // 0A and 0B share factor 6: both fire in short mode, only A in full mode
        wr(dmamc_pkg::OFS_FACTOR, 32'h0066);
        wr(dmamc_pkg::OFS_BAND, 32'h0330);
        c0 = req_cnt[0];
        c1 = req_cnt[1];
        pulse(16'h0040, 16'h0000);
        wait_req(1);
        check("short A", req_cnt[0], c0 + 8'h01);
        check("short B", req_cnt[1], c1 + 8'h01);
        wr(dmamc_pkg::OFS_BAND, 32'h4330);
        c0 = req_cnt[0];
        c1 = req_cnt[1];
        pulse(16'h0040, 16'h0000);
        wait_req(0);
        check("full A", req_cnt[0], c0 + 8'h01);
        check("full B idle", req_cnt[1], c1);
        // Clock enable low freezes the forwarded requests until it returns
        ce <= 1'b0;
        pulse(16'h0100, 16'h0000);
        repeat (3) @(posedge clk_sys);
        check("ce frozen", irq_fwd[8], 1'b0);
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("ce resumed", irq_fwd[8], 1'b1);
        close_out();
    end
endmodule : tb_dma_channel_mode_and_ack_control
